// File: logic/admc_regs.sv
// Mode control register bank: attenuation, soft mute ramp, format and mode bits.
// Assumes a serial port front end that hands over whole 16-bit control words,
// and a frame clock pin that is asynchronous to clock.
module admc_regs #(
	parameter logic [4:0] DEVICE_NUMBER = 5'h05 // Arbitrary value
) (
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        cmd_valid,
	input  wire logic [15:0] cmd_word,
	input  wire logic        frame_clock,
	input  wire logic        left_zero_flag,
	input  wire logic        right_zero_flag,
	output logic             rd_valid,
	output logic [7:0]       rd_data,
	output logic [7:0]       left_atten_code,
	output logic [7:0]       right_atten_code,
	output logic             left_muted,
	output logic             right_muted,
	output logic [2:0]       audio_word_format,
	output logic             format_reserved,
	output logic [1:0]       deemph_rate_select,
	output logic [1:0]       fir_perf_select,
	output logic             deemph_enable,
	output logic             soft_mute_active,
	output logic             output_polarity_invert,
	output logic [1:0]       atten_step_rate,
	output logic             one_bit_stream_mode,
	output logic             system_reset_pulse
);

	logic [7:0] reg_att_l_ff;
	logic [7:0] reg_att_r_ff;
	logic [7:0] reg_fmt_ff;
	logic [7:0] reg_phase_ff;
	logic [7:0] reg_sys_ff;
	logic [7:0] reg_zctl_ff;
	logic [7:0] tgt_l_ff;
	logic [7:0] tgt_r_ff;
	logic [7:0] lvl_l_ff;
	logic [7:0] lvl_r_ff;
	logic [2:0] fsync_ff;
	logic       fstate_ff;
	logic [2:0] frame_cnt_ff;
	logic       step_ff;
	logic       rd_valid_ff;
	logic [7:0] rd_data_ff;
	logic       reset_req_ff;
	logic [7:0] nxt_rd_data;
	logic [7:0] nxt_lvl_l;
	logic [7:0] nxt_lvl_r;
	logic [2:0] frame_div;
	logic       frame_rise;
	logic       wr_en;
	logic       rd_en;
	logic [6:0] idx;
	logic [7:0] wdata;
	logic       soft_reset;

	localparam int ADMC_IDX_LSB_W = admc_pkg::ADMC_IDX_LSB;

	assign idx   = cmd_word[14:ADMC_IDX_LSB_W];
	assign wdata = cmd_word[7:0];
	assign wr_en = cmd_valid && !cmd_word[admc_pkg::ADMC_RW_BIT]; // [RL1]
	assign rd_en = cmd_valid && cmd_word[admc_pkg::ADMC_RW_BIT];  // [RL1]
	assign soft_reset = reset_req_ff;

	// One step toward the target, never overshooting
	function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
		logic [7:0] res;
		res = cur;
		if (cur < tgt) begin
			res = cur + 8'h01;
		end else if (cur > tgt) begin
			res = cur - 8'h01;
		end
		return res;
	endfunction

	function automatic logic is_muted(input logic [7:0] code);
		return code <= admc_pkg::ADMC_MUTE_TOP;
	endfunction

	// System reset bit: one clock wide, never stored in the register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reset_req_ff <= 1'b0;
		end else begin
			reset_req_ff <= wr_en && (idx == admc_pkg::ADMC_IDX_SYS)
				&& wdata[admc_pkg::ADMC_BIT_RESET]; // [RL18]
		end
	end

	// Writable registers; reads of 22 and 23 never write
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reg_att_l_ff <= admc_pkg::ADMC_RST_ATT; // [RL6]
			reg_att_r_ff <= admc_pkg::ADMC_RST_ATT; // [RL6]
			reg_fmt_ff   <= admc_pkg::ADMC_RST_FMT; // [RL8] [RL10] [RL11] [RL13] [RL14]
			reg_phase_ff <= admc_pkg::ADMC_RST_PHASE; // [RL16] [RL17]
			reg_sys_ff   <= admc_pkg::ADMC_RST_SYS;
			reg_zctl_ff  <= admc_pkg::ADMC_RST_ZCTL;
		end else if (soft_reset) begin
			reg_att_l_ff <= admc_pkg::ADMC_RST_ATT; // [RL18]
			reg_att_r_ff <= admc_pkg::ADMC_RST_ATT;
			reg_fmt_ff   <= admc_pkg::ADMC_RST_FMT;
			reg_phase_ff <= admc_pkg::ADMC_RST_PHASE;
			reg_sys_ff   <= admc_pkg::ADMC_RST_SYS;
			reg_zctl_ff  <= admc_pkg::ADMC_RST_ZCTL;
		end else if (wr_en) begin
			unique case (idx)
				admc_pkg::ADMC_IDX_ATT_L: begin
					reg_att_l_ff <= wdata; // [RL3]
				end
				admc_pkg::ADMC_IDX_ATT_R: begin
					reg_att_r_ff <= wdata; // [RL3]
				end
				admc_pkg::ADMC_IDX_FMT: begin
					reg_fmt_ff <= wdata;
				end
				admc_pkg::ADMC_IDX_PHASE: begin
					reg_phase_ff <= wdata & admc_pkg::ADMC_MASK_PHASE;
				end
				admc_pkg::ADMC_IDX_SYS: begin
					reg_sys_ff <= wdata & admc_pkg::ADMC_MASK_SYS;
				end
				admc_pkg::ADMC_IDX_ZCTL: begin
					reg_zctl_ff <= wdata & admc_pkg::ADMC_MASK_ZCTL;
				end
				default: begin
					// Read-only and unmapped indices absorb writes
					reg_att_l_ff <= reg_att_l_ff; // [RL2]
				end
			endcase
		end
	end

	// Targets follow written codes only while the load bit is set
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tgt_l_ff <= admc_pkg::ADMC_RST_ATT;
			tgt_r_ff <= admc_pkg::ADMC_RST_ATT;
		end else if (soft_reset) begin
			tgt_l_ff <= admc_pkg::ADMC_RST_ATT;
			tgt_r_ff <= admc_pkg::ADMC_RST_ATT;
		end else if (wr_en && reg_fmt_ff[admc_pkg::ADMC_BIT_LOAD]) begin
			if (idx == admc_pkg::ADMC_IDX_ATT_L) begin
				tgt_l_ff <= wdata; // [RL7]
			end
			if (idx == admc_pkg::ADMC_IDX_ATT_R) begin
				tgt_r_ff <= wdata; // [RL7]
			end
		end
	end

	// Frame clock pin: three stages, edge seen once stages two and three agree
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fsync_ff  <= 3'h0;
			fstate_ff <= 1'b0;
		end else begin
			fsync_ff <= {fsync_ff[1:0], frame_clock};
			if (fsync_ff[1] == fsync_ff[2]) begin
				fstate_ff <= fsync_ff[2];
			end
		end
	end

	assign frame_rise = (fsync_ff[1] == fsync_ff[2]) && fsync_ff[2] && !fstate_ff;

	// Divider is 1, 2, 4 or 8 frames
	assign frame_div = 3'((4'h1 << reg_phase_ff[admc_pkg::ADMC_STEP_LSB +: 2]) - 4'h1); // [RL17]

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			frame_cnt_ff <= 3'h0;
			step_ff      <= 1'b0;
		end else begin
			step_ff <= 1'b0;
			if (frame_rise) begin
				if (frame_cnt_ff >= frame_div) begin
					frame_cnt_ff <= 3'h0;
					step_ff      <= 1'b1; // [RL17]
				end else begin
					frame_cnt_ff <= frame_cnt_ff + 3'h1;
				end
			end
		end
	end

	// Soft mute drives the target to the floor; the ramp then walks one code per step from the current level down to code 0
	always_comb begin
		nxt_lvl_l = step_toward(lvl_l_ff, reg_fmt_ff[admc_pkg::ADMC_BIT_MUTE] ?
			admc_pkg::ADMC_ATT_FLOOR : tgt_l_ff); // [RL15] [RL19]
		nxt_lvl_r = step_toward(lvl_r_ff, reg_fmt_ff[admc_pkg::ADMC_BIT_MUTE] ?
			admc_pkg::ADMC_ATT_FLOOR : tgt_r_ff); // [RL15] [RL19]
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lvl_l_ff <= admc_pkg::ADMC_RST_ATT;
			lvl_r_ff <= admc_pkg::ADMC_RST_ATT;
		end else if (soft_reset) begin
			lvl_l_ff <= admc_pkg::ADMC_RST_ATT;
			lvl_r_ff <= admc_pkg::ADMC_RST_ATT;
		end else if (step_ff) begin
			lvl_l_ff <= nxt_lvl_l; // [RL19]
			lvl_r_ff <= nxt_lvl_r; // [RL19]
		end
	end

	// Readback; reserved bits are already zero in storage
	always_comb begin
		nxt_rd_data = 8'h00;
		unique case (idx)
			admc_pkg::ADMC_IDX_ATT_L: nxt_rd_data = reg_att_l_ff;
			admc_pkg::ADMC_IDX_ATT_R: nxt_rd_data = reg_att_r_ff;
			admc_pkg::ADMC_IDX_FMT: nxt_rd_data = reg_fmt_ff;
			admc_pkg::ADMC_IDX_PHASE: nxt_rd_data = reg_phase_ff;
			admc_pkg::ADMC_IDX_SYS: nxt_rd_data = reg_sys_ff;
			admc_pkg::ADMC_IDX_ZCTL: nxt_rd_data = reg_zctl_ff;
			admc_pkg::ADMC_IDX_ZFLAG: nxt_rd_data = {6'h00, right_zero_flag, left_zero_flag};
			admc_pkg::ADMC_IDX_DEVNUM: nxt_rd_data = {3'h0, DEVICE_NUMBER};
			default: nxt_rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_valid_ff <= 1'b0;
			rd_data_ff  <= 8'h00;
		end else begin
			rd_valid_ff <= rd_en; // [RL1]
			if (rd_en) begin
				rd_data_ff <= nxt_rd_data;
			end
		end
	end

	// Decoded controls, all registered
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			left_atten_code        <= admc_pkg::ADMC_RST_ATT;
			right_atten_code       <= admc_pkg::ADMC_RST_ATT;
			left_muted             <= 1'b0;
			right_muted            <= 1'b0;
			audio_word_format      <= admc_pkg::ADMC_FMT_I2S24;
			format_reserved        <= 1'b0;
			deemph_rate_select     <= 2'h0;
			fir_perf_select        <= 2'h0;
			deemph_enable          <= 1'b0;
			soft_mute_active       <= 1'b0;
			output_polarity_invert <= 1'b0;
			atten_step_rate        <= 2'h0;
			one_bit_stream_mode    <= 1'b0;
		end else begin
			// Code 255 is unity gain, each code below it is half a dB
			left_atten_code    <= lvl_l_ff; // [RL3] [RL4]
			right_atten_code   <= lvl_r_ff; // [RL3] [RL4]
			left_muted         <= is_muted(lvl_l_ff); // [RL5]
			right_muted        <= is_muted(lvl_r_ff); // [RL5]
			audio_word_format  <= reg_fmt_ff[admc_pkg::ADMC_FMT_LSB +: 3]; // [RL9]
			// Reserved codes are flagged so the datapath can hold off
			// Both 11x codes are reserved, so only the top two field bits matter
			format_reserved    <= reg_fmt_ff[admc_pkg::ADMC_FMT_LSB + 1 +: 2] == 2'h3; // [RL9] [RL20]
			// The same two bits serve one of two meanings
			if (reg_sys_ff[admc_pkg::ADMC_BIT_ONEBIT]) begin
				deemph_rate_select <= 2'h0; // [RL12]
				fir_perf_select    <= reg_fmt_ff[admc_pkg::ADMC_DEEMPH_LSB +: 2]; // [RL12]
			end else begin
				deemph_rate_select <= reg_fmt_ff[admc_pkg::ADMC_DEEMPH_LSB +: 2]; // [RL11]
				fir_perf_select    <= 2'h0;
			end
			deemph_enable          <= reg_fmt_ff[admc_pkg::ADMC_BIT_DEEMPH]; // [RL13]
			soft_mute_active       <= reg_fmt_ff[admc_pkg::ADMC_BIT_MUTE]; // [RL14]
			output_polarity_invert <= reg_phase_ff[admc_pkg::ADMC_BIT_INVERT]; // [RL16]
			atten_step_rate        <= reg_phase_ff[admc_pkg::ADMC_STEP_LSB +: 2]; // [RL17]
			one_bit_stream_mode    <= reg_sys_ff[admc_pkg::ADMC_BIT_ONEBIT];
		end
	end

	assign rd_valid           = rd_valid_ff;
	assign rd_data            = rd_data_ff;
	assign system_reset_pulse = reset_req_ff;

endmodule

// File: shared/admc_pkg.sv
// Constants for the mode control register bank of a stereo audio converter.
// Assumes control words arrive already deserialised, one 16-bit word a strobe.
// Contract
// [RL1] Registers 16..21: word bit 15 high reads back, low stores the data.
// [RL2] Registers 22 and 23 are read-only; host writes change nothing.
// [RL3] Each channel has its own 8-bit attenuation code, 0 dB to -120 dB.
// [RL4] Attenuation in dB is half of (code minus 255); 255 is unity.
// [RL5] Codes 0 through 14 mute that channel completely.
// [RL6] Both attenuation codes reset to all ones.
// [RL7] Shared load bit: when 0 new codes are ignored, when 1 applied.
// [RL8] The load bit resets to 0.
// [RL9] Three-bit format field selects word format; 110 and 111 reserved.
// [RL10] Format field resets to 101, 24-bit I2S.
// [RL11] Two-bit de-emphasis rate: 00 off, 01 48k, 10 44.1k, 11 32k.
// [RL12] In one-bit stream mode the rate field selects FIR filter performance.
// [RL13] One de-emphasis enable for both channels, reset 0.
// [RL14] One soft-mute bit for both channels, reset 0.
// [RL15] Soft mute ramps through 256 steps at the step rate; here one step per code from the current level down to 0, at most 255.
// [RL16] Polarity invert bit flips both channels, reset 0.
// [RL17] Step rate: 00 every frame, 01 every 2, 10 every 4, 11 every 8.
// [RL18] Writing 1 to system reset bit gives one reset pulse; reads as 0.
// [RL19] Applied level steps one code per interval toward the loaded target.
// [RL20] Host must not program the reserved format codes.
package admc_pkg;

	localparam logic [6:0] ADMC_IDX_ATT_L   = 7'h10;
	localparam logic [6:0] ADMC_IDX_ATT_R   = 7'h11;
	localparam logic [6:0] ADMC_IDX_FMT     = 7'h12;
	localparam logic [6:0] ADMC_IDX_PHASE   = 7'h13;
	localparam logic [6:0] ADMC_IDX_SYS     = 7'h14;
	localparam logic [6:0] ADMC_IDX_ZCTL    = 7'h15;
	localparam logic [6:0] ADMC_IDX_ZFLAG   = 7'h16;
	localparam logic [6:0] ADMC_IDX_DEVNUM  = 7'h17;

	// Control word layout
	localparam int         ADMC_RW_BIT      = 15;
	localparam int         ADMC_IDX_LSB     = 8;

	localparam logic [7:0] ADMC_RST_ATT     = 8'hff;
	localparam logic [7:0] ADMC_RST_FMT     = 8'h50;
	localparam logic [7:0] ADMC_RST_PHASE   = 8'h00;
	localparam logic [7:0] ADMC_RST_SYS     = 8'h00;
	localparam logic [7:0] ADMC_RST_ZCTL    = 8'h01;

	// Writable bit masks; reserved and write-only bits read as zero
	localparam logic [7:0] ADMC_MASK_PHASE  = 8'hf7;
	localparam logic [7:0] ADMC_MASK_SYS    = 8'h3f;
	localparam logic [7:0] ADMC_MASK_ZCTL   = 8'h07;

	// Field positions
	localparam int         ADMC_BIT_LOAD    = 7;
	localparam int         ADMC_FMT_LSB     = 4;
	localparam int         ADMC_DEEMPH_LSB  = 2;
	localparam int         ADMC_BIT_DEEMPH  = 1;
	localparam int         ADMC_BIT_MUTE    = 0;
	localparam int         ADMC_BIT_INVERT  = 7;
	localparam int         ADMC_STEP_LSB    = 5;
	localparam int         ADMC_BIT_RESET   = 6;
	localparam int         ADMC_BIT_ONEBIT  = 5;

	localparam logic [7:0] ADMC_MUTE_TOP    = 8'h0e;
	localparam logic [7:0] ADMC_ATT_FLOOR   = 8'h00;

	typedef enum logic [2:0] {
		ADMC_FMT_RJ16 = 3'b000,
		ADMC_FMT_RJ20 = 3'b001,
		ADMC_FMT_RJ24 = 3'b010,
		ADMC_FMT_LJ24 = 3'b011,
		ADMC_FMT_I2S16 = 3'b100,
		ADMC_FMT_I2S24 = 3'b101,
		ADMC_FMT_RES6 = 3'b110,
		ADMC_FMT_RES7 = 3'b111
	} admc_format_t;

endpackage

// File: testbench/admc_regs_chk.sv
// Concurrent checks on the ports of the mode control register bank.
// Assumes one clock domain and the asynchronous active-low reset.
module admc_regs_chk (
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic        cmd_valid,
	input wire logic [15:0] cmd_word,
	input wire logic        rd_valid,
	input wire logic [7:0]  left_atten_code,
	input wire logic        left_muted,
	input wire logic [2:0]  audio_word_format,
	input wire logic        format_reserved,
	input wire logic [1:0]  deemph_rate_select,
	input wire logic        one_bit_stream_mode,
	input wire logic        system_reset_pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire rd_cmd = cmd_valid && cmd_word[15];
	wire wr_cmd = cmd_valid && !cmd_word[15];

	read_answer_a: assert property (rd_cmd |=> rd_valid)
		else $error("read word not answered");
	write_quiet_a: assert property (wr_cmd |=> !rd_valid)
		else $error("write word answered");
	pulse_once_a: assert property (system_reset_pulse |=> !system_reset_pulse)
		else $error("reset pulse longer than one cycle");
	pulse_cause_a: assert property ($rose(system_reset_pulse) |->
		$past(wr_cmd && cmd_word[14:8] == 7'h14 && cmd_word[6]))
		else $error("reset pulse without its write");
	reset_defaults_a: assert property (system_reset_pulse |-> ##2
		audio_word_format == 3'b101 && left_atten_code == 8'hff)
		else $error("soft reset left non-default state");
	// Soft reset jumps the level, seen at the output two edges after its pulse
	step_one_a: assert property ($changed(left_atten_code)
		&& !$past(system_reset_pulse, 2)
		|-> 8'(left_atten_code - $past(left_atten_code)) inside {8'h01, 8'hff})
		else $error("level moved by more than one code");
	mute_map_a: assert property ($stable(left_atten_code) [*2] |->
		left_muted == (left_atten_code <= 8'h0e))
		else $error("mute flag disagrees with level");
	reserved_flag_a: assert property (format_reserved == (audio_word_format[2:1] == 2'b11))
		else $error("reserved format flag wrong");
	onebit_rate_a: assert property (one_bit_stream_mode |-> deemph_rate_select == 2'b00)
		else $error("de-emphasis rate live in one-bit mode");

	cover property (rd_cmd);
	cover property (system_reset_pulse);
	cover property (left_muted);
endmodule

bind admc_regs admc_regs_chk i_admc_regs_chk (.*);

// File: testbench/admc_host.sv
// Host controller model: sends whole control words at falling edges.
// Assumes the device takes a word at the rising edge with cmd_valid high.
module admc_host (
	input  wire logic   clock,
	output logic        cmd_valid,
	output logic [15:0] cmd_word
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_valid = 1'b0;
		cmd_word  = 16'h0000;
	end
	// Released word shows its inverse so stale data cannot pass as valid
	task automatic send(input logic [15:0] w);
		@(negedge clock);
		cmd_valid <= 1'b1;
		cmd_word  <= w;
		@(negedge clock);
		cmd_valid <= 1'b0;
		cmd_word  <= ~w;
	endtask
	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		send({1'b0, idx, d});
	endtask
	task automatic rd(input logic [6:0] idx);
		send({1'b1, idx, 8'h00});
	endtask
endmodule

// File: testbench/test_admc_regs.sv
// Self-checking bench for the mode control register bank.
// Assumes the host model drives words; reads are checked by a monitor queue.
module test_admc_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] DEV = 5'h0b; // Arbitrary value
	logic        clock = 1'b0, arst_n = 1'b0, frame_clock = 1'b0;
	logic        left_zero_flag = 1'b0, right_zero_flag = 1'b0;
	logic        cmd_valid, rd_valid, left_muted, right_muted, format_reserved;
	logic        deemph_enable, soft_mute_active, output_polarity_invert;
	logic        one_bit_stream_mode, system_reset_pulse;
	logic [15:0] cmd_word;
	logic [7:0]  rd_data, left_atten_code, right_atten_code, rt, r;
	logic [2:0]  audio_word_format;
	logic [1:0]  deemph_rate_select, fir_perf_select, atten_step_rate;
	int          fail_count = 0, n_compared = 0, seed = 16092;
	logic [7:0]  exp_q[$];

	admc_regs #(.DEVICE_NUMBER(DEV)) i_admc_regs (.*);
	admc_host i_admc_host (.*);

	always #25 clock = ~clock;
	// Frame of 20 system clocks keeps ramps short
	always begin
		repeat (10) @(negedge clock);
		frame_clock <= ~frame_clock;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rdx(input logic [6:0] idx, input logic [7:0] exp);
		exp_q.push_back(exp);
		i_admc_host.rd(idx);
	endtask
	task automatic wait_lvl(input logic [7:0] l, input logic [7:0] rr, input int lim);
		int k;
		for (k = 0; k < lim && !(left_atten_code === l && right_atten_code === rr); k++)
			@(negedge clock);
		check("left level", left_atten_code, l);
		check("right level", right_atten_code, rr);
	endtask
	task automatic test_done();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(negedge clock) begin
		if (rd_valid === 1'b1)
			check("read data", rd_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
	end

	initial begin
		repeat (40000) @(negedge clock);
		fail_count++;
		test_done();
	end

	initial begin
		repeat (12) @(negedge clock);
		arst_n <= 1'b1;
		check("reset level", right_atten_code, 8'hff);
		check("reset format", {5'h00, audio_word_format}, 8'h05);
		check("reset mute", {7'h00, soft_mute_active}, 8'h00);
		rdx(7'h10, 8'hff);
		rdx(7'h12, 8'h50);
		rdx(7'h13, 8'h00);
		i_admc_host.wr(7'h10, 8'h40);
		rdx(7'h10, 8'h40);
		repeat (80) @(negedge clock);
		check("gated level", left_atten_code, 8'hff);
		rt = 8'h80 | 8'($random(seed));
		i_admc_host.wr(7'h12, 8'hd0);
		i_admc_host.wr(7'h10, 8'h0e);
		i_admc_host.wr(7'h11, rt);
		wait_lvl(8'h0e, rt, 6000);
		check("left muted", {7'h00, left_muted}, 8'h01);
		i_admc_host.wr(7'h13, 8'he0);
		repeat (2) @(negedge clock);
		check("step rate", {6'h00, atten_step_rate}, 8'h03);
		check("polarity", {7'h00, output_polarity_invert}, 8'h01);
		i_admc_host.wr(7'h10, 8'h12);
		repeat (400) @(negedge clock);
		check("slow ramp", {7'h00, left_atten_code === 8'h12}, 8'h00);
		wait_lvl(8'h12, rt, 500);
		check("left unmuted", {7'h00, left_muted}, 8'h00);
		i_admc_host.wr(7'h13, 8'h80);
		i_admc_host.wr(7'h12, 8'h91);
		wait_lvl(8'h00, 8'h00, 6000);
		check("soft mute", {7'h00, soft_mute_active}, 8'h01);
		check("right muted", {7'h00, right_muted}, 8'h01);
		// Reserved format codes are never sent by the host
		for (int f = 0; f < 6; f++) begin
			r = 8'($random(seed));
			i_admc_host.wr(7'h12, {1'b1, f[2:0], r[3:0]});
			repeat (2) @(negedge clock);
			check("format", {5'h00, audio_word_format}, {5'h00, f[2:0]});
			check("deemph rate", {6'h00, deemph_rate_select}, {6'h00, r[3:2]});
			check("deemph on", {7'h00, deemph_enable}, {7'h00, r[1]});
			check("mute on", {7'h00, soft_mute_active}, {7'h00, r[0]});
			rdx(7'h12, {1'b1, f[2:0], r[3:0]});
		end
		i_admc_host.wr(7'h14, 8'h20);
		i_admc_host.wr(7'h12, 8'h5c);
		repeat (2) @(negedge clock);
		check("fir select", {6'h00, fir_perf_select}, 8'h03);
		check("one-bit mode", {7'h00, one_bit_stream_mode}, 8'h01);
		check("rate in one-bit", {6'h00, deemph_rate_select}, 8'h00);
		rdx(7'h14, 8'h20);
		left_zero_flag <= 1'b1;
		i_admc_host.wr(7'h16, 8'h00);
		i_admc_host.wr(7'h17, 8'h00);
		rdx(7'h16, 8'h01);
		rdx(7'h17, {3'h0, DEV});
		rdx(7'h30, 8'h00);
		i_admc_host.wr(7'h14, 8'h40);
		repeat (3) @(negedge clock);
		check("soft reset", {7'h00, output_polarity_invert}, 8'h00);
		rdx(7'h12, 8'h50);
		rdx(7'h14, 8'h00);
		repeat (5) @(negedge clock);
		test_done();
	end
endmodule
